// file: shared/fan_flags_pkg.sv
/*
  Constants, field layouts and carriers for the fan and temperature
  status flag block. Assumes one 100 MHz clock domain.
*/
package fan_flags_pkg;
  localparam int unsigned CLK_HZ          = 100000000;
  localparam int unsigned FAST_PERIOD_MS  = 250;
  localparam int unsigned SLOW_PERIOD_MS  = 1000;
  localparam int unsigned FAST_CYC        = CLK_HZ / 1000 * FAST_PERIOD_MS;
  localparam int unsigned SLOW_CYC        = CLK_HZ / 1000 * SLOW_PERIOD_MS;

  localparam logic [7:0] OFS_FAN_CONFIG_FOUR  = 8'h04;
  localparam logic [7:0] OFS_ALARM_STATUS_ONE = 8'h02;
  localparam logic [7:0] OFS_IRQ_ENABLE       = 8'h05;
  localparam logic [7:0] OFS_SOFT_RESET       = 8'h06;

  localparam logic [7:0] CFG4_RESET    = 8'h08;
  localparam logic [7:0] CFG4_RSVD_VAL = 8'h08;
  localparam int unsigned CFG_MODE_BIT = 7;
  localparam int unsigned CFG_PPR_BIT  = 6;
  localparam int unsigned CFG_FAST_BIT = 5;
  localparam int unsigned CFG_OVR_BIT  = 4;

  localparam int unsigned IE_FAIL_BIT  = 2;
  localparam int unsigned IE_SHDN_BIT  = 1;
  localparam int unsigned IE_FAN_BIT   = 0;

  localparam int unsigned ST_LLOW  = 7;
  localparam int unsigned ST_LHIGH = 6;
  localparam int unsigned ST_RFAIL = 5;
  localparam int unsigned ST_RSHDN = 4;
  localparam int unsigned ST_RLOW  = 3;
  localparam int unsigned ST_RHIGH = 2;
  localparam int unsigned ST_SLOW  = 1;
  localparam int unsigned ST_OVSPD = 0;

  localparam logic signed [7:0] REMOTE_FAIL_TEMP = 8'sh80;
  localparam logic signed [8:0] SHDN_HYST_C      = 9'sh005;
  localparam logic [2:0]        FAN_FAIL_COUNT   = 3'h5;
  localparam logic [7:0]        SOFT_RESET_KEY   = 8'h01;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic signed [7:0] local_temp;
    logic signed [7:0] remote_temp;
    logic signed [7:0] local_low;
    logic signed [7:0] local_high;
    logic signed [7:0] remote_low;
    logic signed [7:0] remote_high;
    logic signed [7:0] remote_shdn;
    logic        [15:0] tach_low;
    logic        [15:0] tach_high;
  } limits_t;
endpackage : fan_flags_pkg

// file: hw/fan_temp_status_flags.sv
/*
  Configuration register four, alarm status register one and the
  alarm pins of the fan and temperature monitor.
  Assumes temperatures and limits come from same-clock logic, while the
  sensor fault and tach pulse inputs arrive from pins.
*/
`timescale 1ns/1ps

module fan_temp_status_flags
  import fan_flags_pkg::*;
#(
  parameter int unsigned FAST_CYCLES = FAST_CYC,
  parameter int unsigned SLOW_CYCLES = SLOW_CYC
)(
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  input  wire fan_flags_pkg::reg_req_t req,
  output logic [7:0]                rdata,
  input  wire fan_flags_pkg::limits_t lim,
  input  wire logic                 sensor_fault,
  input  wire logic                 tach_pulse,
  input  wire logic                 spin_up,
  output logic                      pulses_per_rev_sel,
  output logic                      mode_ok,
  output logic [15:0]               tach_count,
  output logic signed [7:0]         remote_temp_out,
  output logic                      alert_n,
  output logic                      shutdown_out_n,
  output logic                      fan_fault_n,
  output logic                      overtemp_out_o,
  output logic                      overtemp_out_oe
);
  import fan_flags_pkg::*;

  logic [7:0] cfg_r;
  logic [2:0] ie_r;
  logic [7:0] flags_r;
  logic [7:0] rdata_r;
  logic       shdn_armed_r;
  logic       ovspd_armed_r;
  logic       spin_up_d_r;
  logic signed [7:0] rtemp_r;
  logic [2:0] slow_cnt_r;
  logic       fan_fail_r;
  logic [31:0] tick_cnt_r;
  logic [15:0] pulse_cnt_r;
  logic [15:0] tach_r;
  logic       soft_rst_r;
  logic [1:0] fault_sync_r;
  logic [1:0] tach_sync_r;
  logic       tach_prev_r;
  logic       alert_n_r;
  logic       shdn_n_r;
  logic       fan_fault_n_r;
  logic       ot_o_r;
  logic       ot_oe_r;

  // one place for the address match, shared by writes and read-back
  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] ofs);
    return a == ofs;
  endfunction : addr_hit

  // decode
  wire wr_cfg   = req.wr && addr_hit(req.addr, OFS_FAN_CONFIG_FOUR);
  wire wr_ie    = req.wr && addr_hit(req.addr, OFS_IRQ_ENABLE);
  wire wr_srst  = req.wr && addr_hit(req.addr, OFS_SOFT_RESET)
                  && (req.wdata == SOFT_RESET_KEY);
  wire rd_stat  = req.rd && addr_hit(req.addr, OFS_ALARM_STATUS_ONE);

  wire [7:0] cfg_nxt = {req.wdata[7:4], CFG4_RSVD_VAL[3:0]};
  wire       fast    = cfg_r[CFG_FAST_BIT];

  // one monitoring cycle ends each speed update
  wire [31:0] period = fast ? FAST_CYCLES : SLOW_CYCLES;
  wire        tick   = (tick_cnt_r >= period - 32'h1);

  wire fault_s = fault_sync_r[1];
  wire tach_s  = tach_sync_r[1];
  wire tach_rise = tach_s && !tach_prev_r;

  // remote reading replaced while the sensor is bad
  wire signed [7:0] rtemp = fault_s ? REMOTE_FAIL_TEMP
                                    : lim.remote_temp;

  wire c_llow  = lim.local_temp <= lim.local_low;
  wire c_lhigh = lim.local_temp >= lim.local_high;
  wire c_rlow  = rtemp <= lim.remote_low;
  wire c_rhigh = rtemp >= lim.remote_high;
  wire c_rshdn = rtemp > lim.remote_shdn;
  wire signed [8:0] shdn_rearm_lvl =
    9'(lim.remote_shdn) - SHDN_HYST_C;
  wire c_cool  = 9'(rtemp) <= shdn_rearm_lvl;
  wire c_slow  = !spin_up && (tach_r >= lim.tach_low);
  wire c_ovspd = tach_r <= lim.tach_high;

  // end of spin-up raises the slow flag at once, not on the next tick,
  // so a read right after spin-up already sees it; the read then clears
  // it like any resolved condition
  wire spin_end = spin_up_d_r && !spin_up;

  // conditions sampled on the monitoring tick
  wire [7:0] cond = {c_llow, c_lhigh, fault_s, c_rshdn & shdn_armed_r,
                     c_rlow, c_rhigh, c_slow,
                     c_ovspd & ovspd_armed_r};
  wire [7:0] cond_now = {c_llow, c_lhigh, fault_s, c_rshdn,
                         c_rlow, c_rhigh, c_slow, c_ovspd};
  wire [7:0] set_v = {8{tick}} & cond;
  // sensor fail does not wait for a tick
  wire [7:0] set_any = set_v | (8'(fault_s) << ST_RFAIL)
                       | (8'(spin_end) << ST_SLOW);

  // a read clears only resolved bits it actually returned; sensor fail stays
  wire [7:0] clr_mask = {8{rd_stat}} & flags_r & ~cond_now
                        & ~(8'h01 << ST_RFAIL);
  // an overspeed or shutdown bit read while still active is cleared too
  // but kept unarmed; that is the hysteresis.
  wire clr_shdn  = rd_stat && flags_r[ST_RSHDN];
  wire clr_ovspd = rd_stat && flags_r[ST_OVSPD];
  wire [7:0] clr_all = clr_mask | ({7'h00, clr_ovspd} << ST_OVSPD)
                       | ({7'h00, clr_shdn} << ST_RSHDN);
  wire [7:0] flags_nxt = (flags_r & ~clr_all) | set_any;

  wire fan_irq  = ie_r[IE_FAN_BIT] &&
                  (flags_r[ST_SLOW] || flags_r[ST_OVSPD]);
  wire shdn_irq = ie_r[IE_SHDN_BIT] && flags_r[ST_RSHDN];
  wire fail_irq = ie_r[IE_FAIL_BIT] && flags_r[ST_RFAIL];

  wire [7:0] rd_mux =
    addr_hit(req.addr, OFS_FAN_CONFIG_FOUR)  ? cfg_r :
    addr_hit(req.addr, OFS_ALARM_STATUS_ONE) ? flags_r :
    addr_hit(req.addr, OFS_IRQ_ENABLE)       ? {5'h00, ie_r} : 8'h00;

  // pulses to revolutions: four pulses per rev halves the count
  wire [15:0] tach_nxt = cfg_r[CFG_PPR_BIT] ? {1'b0, pulse_cnt_r[15:1]}
                                            : pulse_cnt_r;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fault_sync_r <= 2'h0;
      tach_sync_r  <= 2'h0;
      tach_prev_r  <= 1'b0;
    end
    else
    begin
      fault_sync_r <= {fault_sync_r[0], sensor_fault};
      tach_sync_r  <= {tach_sync_r[0], tach_pulse};
      tach_prev_r  <= tach_s;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_r <= CFG4_RESET;
      ie_r  <= 3'h0;
    end
    else if (soft_rst_r)
    begin
      cfg_r <= CFG4_RESET;
      ie_r  <= 3'h0;
    end
    else
    begin
      if (wr_cfg)
        cfg_r <= cfg_nxt;
      if (wr_ie)
        ie_r <= req.wdata[2:0];
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tick_cnt_r  <= 32'h0;
      pulse_cnt_r <= 16'h0;
      tach_r      <= 16'h0;
    end
    else if (soft_rst_r)
    begin
      // software reset restarts the measurement window as well
      tick_cnt_r  <= 32'h0;
      pulse_cnt_r <= 16'h0;
      tach_r      <= 16'h0;
    end
    else if (tick)
    begin
      tick_cnt_r  <= 32'h0;
      pulse_cnt_r <= 16'h0;
      tach_r      <= tach_nxt;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      if (tach_rise && pulse_cnt_r != 16'hFFFF)
        pulse_cnt_r <= pulse_cnt_r + 16'h1;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flags_r       <= 8'h00;
      shdn_armed_r  <= 1'b1;
      ovspd_armed_r <= 1'b1;
      spin_up_d_r   <= 1'b0;
      slow_cnt_r    <= 3'h0;
      fan_fail_r    <= 1'b0;
      soft_rst_r    <= 1'b0;
    end
    else
    begin
      soft_rst_r  <= wr_srst;
      spin_up_d_r <= spin_up;
      if (soft_rst_r)
      begin
        flags_r       <= 8'h00;
        shdn_armed_r  <= 1'b1;
        ovspd_armed_r <= 1'b1;
        slow_cnt_r    <= 3'h0;
        fan_fail_r    <= 1'b0;
      end
      else
      begin
        flags_r <= flags_nxt;
        if (clr_shdn)
          shdn_armed_r <= 1'b0;
        else if (c_cool)
          shdn_armed_r <= 1'b1;
        if (clr_ovspd)
          ovspd_armed_r <= 1'b0;
        else if (!c_ovspd)
          ovspd_armed_r <= 1'b1;
        if (tick)
        begin
          if (c_slow && slow_cnt_r != FAN_FAIL_COUNT)
            slow_cnt_r <= slow_cnt_r + 3'h1;
          else if (!c_slow)
            slow_cnt_r <= 3'h0;
        end
        // fail status latched; only the slow count feeds it
        fan_fail_r <= fan_fail_r ||
                      (slow_cnt_r == FAN_FAIL_COUNT);
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_r       <= 8'h00;
      alert_n_r     <= 1'b1;
      shdn_n_r      <= 1'b1;
      fan_fault_n_r <= 1'b1;
      ot_o_r        <= 1'b1;
      ot_oe_r       <= 1'b0;
      rtemp_r       <= 8'sh00;
    end
    else
    begin
      rdata_r       <= req.rd ? rd_mux : 8'h00;
      rtemp_r       <= rtemp;
      alert_n_r     <= !(fan_irq || shdn_irq || fail_irq);
      shdn_n_r      <= !flags_r[ST_RSHDN];
      fan_fault_n_r <= !fan_fail_r;
      ot_o_r        <= !flags_r[ST_RFAIL];
      ot_oe_r       <= cfg_r[CFG_OVR_BIT];
    end
  end

  assign rdata              = rdata_r;
  assign alert_n            = alert_n_r;
  assign shutdown_out_n     = shdn_n_r;
  assign fan_fault_n        = fan_fault_n_r;
  assign overtemp_out_o     = ot_o_r;
  assign overtemp_out_oe    = ot_oe_r;
  assign pulses_per_rev_sel = cfg_r[CFG_PPR_BIT];
  assign mode_ok            = cfg_r[CFG_MODE_BIT];
  assign tach_count         = tach_r;
  assign remote_temp_out    = rtemp_r;
endmodule : fan_temp_status_flags

// file: test/fan_temp_status_flags_properties.sv
/*
  Port-level checks for the fan and temperature status flag block.
  Assumes one clock domain and binding onto fan_temp_status_flags.
*/
`timescale 1ns/1ps
module fan_flags_checker
  import fan_flags_pkg::*;
#(
  parameter int unsigned FAST_CYCLES = 20,
  parameter int unsigned SLOW_CYCLES = 80
)(
  input wire logic                     clock,
  input wire logic                     arst_n,
  input wire fan_flags_pkg::reg_req_t  req,
  input wire logic [7:0]               rdata,
  input wire fan_flags_pkg::limits_t   lim,
  input wire logic                     sensor_fault,
  input wire logic                     pulses_per_rev_sel,
  input wire logic [15:0]              tach_count,
  input wire logic signed [7:0]        remote_temp_out,
  input wire logic                     shutdown_out_n,
  input wire logic                     fan_fault_n,
  input wire logic                     overtemp_out_o,
  input wire logic                     overtemp_out_oe
);
  import fan_flags_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire srst_w = req.wr && req.addr == OFS_SOFT_RESET
                && req.wdata == SOFT_RESET_KEY;
  sequence s_cfg_wr;
    req.wr && req.addr == OFS_FAN_CONFIG_FOUR;
  endsequence
  sequence s_cfg_rd;
    req.rd && req.addr == OFS_FAN_CONFIG_FOUR;
  endsequence
  property p_rd_idle;
    !req.rd |=> rdata == 8'h00;
  endproperty
  property p_cfg_rsvd;
    s_cfg_rd |=> rdata[3:0] == 4'h8;
  endproperty
  property p_ppr;
    s_cfg_wr |=> pulses_per_rev_sel == $past(req.wdata[CFG_PPR_BIT]);
  endproperty
  property p_oe;
    s_cfg_wr |=> ##1 overtemp_out_oe == $past(req.wdata[CFG_OVR_BIT], 2);
  endproperty
  property p_fail_temp;
    $rose(sensor_fault) |-> ##[1:3] remote_temp_out == REMOTE_FAIL_TEMP;
  endproperty
  property p_fail_ovr;
    $rose(sensor_fault) |-> ##[1:5] !overtemp_out_o;
  endproperty
  // software reset may release the pin up to three cycles after its write
  property p_fail_hold;
    !overtemp_out_o && !srst_w && !$past(srst_w) && !$past(srst_w, 2)
      |=> !overtemp_out_o;
  endproperty
  // pin lags the flag, so the cause is looked for two or three back
  property p_shdn_cause;
    $fell(shutdown_out_n) |-> $past(lim.remote_temp > lim.remote_shdn, 2)
      || $past(lim.remote_temp > lim.remote_shdn, 3);
  endproperty
  property p_fault_cause;
    $fell(fan_fault_n) |-> tach_count >= lim.tach_low;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside read");
  a_cfg_rsvd: assert property (p_cfg_rsvd)
    else $error("reserved config bits wrong");
  a_ppr: assert property (p_ppr)
    else $error("pulse select not written");
  a_oe: assert property (p_oe)
    else $error("overtemp enable not following config");
  a_fail_temp: assert property (p_fail_temp)
    else $error("remote temp not forced on fault");
  a_fail_ovr: assert property (p_fail_ovr)
    else $error("overtemp pin not asserted on fault");
  a_fail_hold: assert property (p_fail_hold)
    else $error("sensor fail released before reset");
  a_shdn_cause: assert property (p_shdn_cause)
    else $error("shutdown pin low without cause");
  a_fault_cause: assert property (p_fault_cause)
    else $error("fan fault without slow count");
endmodule : fan_flags_checker

bind fan_temp_status_flags fan_flags_checker #(
  .FAST_CYCLES(FAST_CYCLES),
  .SLOW_CYCLES(SLOW_CYCLES)
) i_chk (
  .clock(clock),
  .arst_n(arst_n),
  .req(req),
  .rdata(rdata),
  .lim(lim),
  .sensor_fault(sensor_fault),
  .pulses_per_rev_sel(pulses_per_rev_sel),
  .tach_count(tach_count),
  .remote_temp_out(remote_temp_out),
  .shutdown_out_n(shutdown_out_n),
  .fan_fault_n(fan_fault_n),
  .overtemp_out_o(overtemp_out_o),
  .overtemp_out_oe(overtemp_out_oe)
);

// file: test/fan_sensor_model.sv
/*
  Stand-in for the fan tachometer and the remote sensor diode.
  Assumes the bench sets the tach half period and the fault request.
*/
`timescale 1ns/1ps
module fan_sensor_model (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic [3:0] half_period,
  input  wire logic       fault_req,
  output logic            tach_pulse,
  output logic            sensor_fault
);
  logic [3:0] cnt_r;
  // a broken diode gives a plain level, no clean edge
  assign sensor_fault = fault_req;
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r      <= 4'h0;
      tach_pulse <= 1'b0;
    end
    else if (cnt_r == half_period - 4'h1)
    begin
      cnt_r      <= 4'h0;
      tach_pulse <= ~tach_pulse;
    end
    else
      cnt_r <= cnt_r + 4'h1;
  end
endmodule : fan_sensor_model

// file: test/fan_temp_status_flags_tb.sv
/*
  Self-checking bench for the status flag block.
  Assumes the tach and sensor stand-in of fan_sensor_model.
*/
`timescale 1ns/1ps
module fan_temp_status_flags_tb;
  import fan_flags_pkg::*;
  localparam int unsigned FC = 20;
  localparam int unsigned SC = 80;
  localparam int unsigned T  = FC + 5;
  localparam logic [7:0]  ST = OFS_ALARM_STATUS_ONE;
  localparam logic [7:0]  CF = OFS_FAN_CONFIG_FOUR;
  logic              clock     = 1'b0;
  logic              arst_n    = 1'b0;
  reg_req_t          req       = '0;
  limits_t           lim;
  logic              spin_up   = 1'b0;
  logic              fault_req = 1'b0;
  logic [7:0]        rdata;
  logic [15:0]       tach_count;
  logic signed [7:0] remote_temp_out;
  logic              tach_pulse, sensor_fault, ppr, mode_ok, alert_n;
  logic              shdn_n, fault_n, ovr_o, ovr_oe;
  int                bad_count = 0;
  int                checks    = 0;
  int                cyc       = 0;
  logic [7:0]        exp_t [4] = '{8'h80, 8'h40, 8'h08, 8'h04};

  fan_temp_status_flags #(.FAST_CYCLES(FC), .SLOW_CYCLES(SC)) i_dut (
    .clock(clock), .arst_n(arst_n), .req(req), .rdata(rdata), .lim(lim),
    .sensor_fault(sensor_fault), .tach_pulse(tach_pulse),
    .spin_up(spin_up), .pulses_per_rev_sel(ppr), .mode_ok(mode_ok),
    .tach_count(tach_count), .remote_temp_out(remote_temp_out),
    .alert_n(alert_n), .shutdown_out_n(shdn_n), .fan_fault_n(fault_n),
    .overtemp_out_o(ovr_o), .overtemp_out_oe(ovr_oe));
  fan_sensor_model i_fan (
    .clock(clock), .arst_n(arst_n), .half_period(4'h2),
    .fault_req(fault_req), .tach_pulse(tach_pulse),
    .sensor_fault(sensor_fault));

  always #5 clock = ~clock;

  task automatic end_sim();
    $display("TB: checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      end_sim();
    end
  end

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clock);
    req.wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    @(posedge clock);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clock);
    req.rd   <= 1'b0;
    #1;
    chk((rdata & m) === e, "read data mismatch");
  endtask : rd

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt

  initial
  begin
    lim = '{8'h19, 8'h19, 8'h00, 8'h3C, 8'h00, 8'h3C, 8'h50, 16'hFFFF,
            16'h0000};
    wt(3);
    arst_n <= 1'b1;
    rd(CF, 8'hFF, CFG4_RESET);
    rd(ST, 8'hFF, 8'h00);
    wr(CF, 8'hFF);
    rd(CF, 8'hFF, 8'hF8);
    chk(ppr === 1'b1 && mode_ok === 1'b1 && ovr_oe === 1'b1, "cfg");
    wr(8'h7F, 8'h00);
    rd(8'h7F, 8'hFF, 8'h00);
    rd(CF, 8'hFF, 8'hF8);
    wr(CF, 8'hA0);
    wt(2 * T);
    chk(tach_count inside {[16'h4:16'h6]} && ovr_oe === 1'b0, "fast");
    wr(CF, 8'hE0);
    wt(2 * T);
    chk(tach_count inside {[16'h2:16'h3]}, "four pulses");
    wr(CF, 8'h80);
    wt(2 * SC + 10);
    chk(tach_count inside {[16'h13:16'h15]}, "slow");
    rd(ST, 8'hFF, 8'h01);
    wr(CF, 8'hA0);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      lim.local_temp  <= (i == 0) ? 8'h00 : (i == 1) ? 8'h3C : 8'h19;
      lim.remote_temp <= (i == 2) ? 8'h00 : (i == 3) ? 8'h3C : 8'h19;
      wt(T);
      lim.local_temp  <= 8'h19;
      lim.remote_temp <= 8'h19;
      rd(ST, 8'hFF, exp_t[i]);
      rd(ST, 8'hFF, 8'h00);
    end
    lim.remote_temp <= 8'h3C;
    wt(T);
    rd(ST, 8'hFF, 8'h04);
    rd(ST, 8'hFF, 8'h04);
    wt(T);
    rd(ST, 8'hFF, 8'h04);
    lim.remote_temp <= 8'h51;
    wt(T);
    chk(shdn_n === 1'b0, "shutdown pin");
    rd(ST, 8'h10, 8'h10);
    wt(T);
    rd(ST, 8'h10, 8'h00);
    chk(shdn_n === 1'b1, "shutdown pin release");
    lim.remote_temp <= 8'h4C;
    wt(T);
    lim.remote_temp <= 8'h51;
    wt(T);
    rd(ST, 8'h10, 8'h00);
    lim.remote_temp <= 8'h4B;
    wt(T);
    lim.remote_temp <= 8'h51;
    wt(T);
    rd(ST, 8'h10, 8'h10);
    lim.remote_temp <= 8'h19;
    rd(ST, 8'h14, 8'h04);
    rd(ST, 8'hFF, 8'h00);
    wr(OFS_IRQ_ENABLE, 8'h01);
    lim.tach_high <= 16'h000A;
    wt(T);
    chk(alert_n === 1'b0 && fault_n === 1'b1, "overspeed alert");
    rd(ST, 8'hFF, 8'h01);
    wt(T);
    rd(ST, 8'hFF, 8'h00);
    lim.tach_high <= 16'h0000;
    wt(T);
    lim.tach_high <= 16'h000A;
    wt(6 * T);
    chk(fault_n === 1'b1, "overspeed fault pin");
    rd(ST, 8'hFF, 8'h01);
    lim.tach_high <= 16'h0000;
    spin_up <= 1'b1;
    wt(T);
    spin_up <= 1'b0;
    wt(4);
    rd(ST, 8'h02, 8'h02);
    rd(ST, 8'h02, 8'h00);
    fault_req <= 1'b1;
    wt(5);
    chk(remote_temp_out === 8'sh80 && ovr_o === 1'b0, "sensor fail");
    fault_req <= 1'b0;
    wt(T);
    rd(ST, 8'h20, 8'h20);
    rd(ST, 8'h20, 8'h20);
    lim.tach_low <= 16'h0003;
    wt(6 * T);
    chk(fault_n === 1'b0 && alert_n === 1'b0, "fan failure");
    rd(ST, 8'h02, 8'h02);
    wr(OFS_SOFT_RESET, SOFT_RESET_KEY);
    wt(2);
    rd(ST, 8'h20, 8'h00);
    rd(CF, 8'hFF, CFG4_RESET);
    chk(fault_n === 1'b1 && ovr_o === 1'b1, "soft reset pins");
    end_sim();
  end
endmodule : fan_temp_status_flags_tb
